// ==== kdsc_pkg.sv ====
// Package: constants, encodings and state layout of the keyboard/display scan controller
package kdsc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ = 100_000_000;
    localparam int SCAN_HZ = 180;
    localparam int POS_PER_SCAN = 16;
    localparam int ROW_CYC = CLK_HZ / (SCAN_HZ * POS_PER_SCAN);
    localparam longint PROC_CLK_HZ = 740_000;
    localparam longint DEB_MS = 11;
    localparam longint DEB_PCLK = PROC_CLK_HZ * DEB_MS / 1000;
    localparam int DEB_CYC = int'(DEB_PCLK * CLK_HZ / PROC_CLK_HZ);
    localparam int CNT_W = 32;

    // ****************************************************************
    // Register map (byte addresses) and field positions
    // ****************************************************************
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_SEL = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_KEY = 4'hc;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_ACC_LSB = 8;
    localparam int SEL_ODD_LSB = 0;
    localparam int SEL_EVEN_LSB = 4;
    localparam int ST_CNT_LSB = 0;
    localparam int ST_OVER = 4;
    localparam int ST_SEL = 5;
    localparam int ST_REGB = 6;
    localparam int ST_BLANK = 7;
    localparam int ST_IN_LSB = 8;
    localparam int ST_OUT_LSB = 10;
    localparam int ST_PTR_LSB = 12;
    localparam int ST_AB = 17;
    localparam int ST_ACC_LSB = 20;

    // ****************************************************************
    // Instruction codes and select nibbles
    // ****************************************************************
    localparam logic [7:0] OP_WRM = 8'he0;
    localparam logic [7:0] OP_WMP = 8'he1;
    localparam logic [7:0] OP_MODE = 8'he4;
    localparam logic [7:0] OP_PRST = 8'he5;
    localparam logic [7:0] OP_CLR = 8'he7;
    localparam logic [7:0] OP_RDM = 8'he9;
    localparam logic [7:0] OP_RD3 = 8'hef;
    localparam logic [1:0] CHIP_ADDR = 2'h1;
    localparam logic [3:0] SEL_BHI = 4'h7;

    // ****************************************************************
    // Modes, blank codes, sizes
    // ****************************************************************
    localparam logic [1:0] OUT_INDIV = 2'h0;
    localparam logic [1:0] OUT_GAS20 = 2'h1;
    localparam logic [1:0] OUT_GAS18 = 2'h2;
    localparam logic [1:0] OUT_GAS16 = 2'h3;
    localparam logic [1:0] IN_SENSOR = 2'h0;
    localparam logic [1:0] IN_SCANKB = 2'h1;
    localparam logic [1:0] IN_ENC = 2'h2;
    localparam logic [1:0] IN_UNUSED = 2'h3;
    localparam logic [3:0] BLANK_IND = 4'hf;
    localparam logic [3:0] BLANK_GAS_A = 4'h2;
    localparam logic [3:0] BLANK_GAS_B = 4'h0;
    localparam logic [4:0] GAS_LEN16 = 5'h10;
    localparam logic [4:0] GAS_LEN18 = 5'h12;
    localparam logic [4:0] GAS_LEN20 = 5'h14;
    localparam logic [4:0] IND_LEN = 5'h10;
    localparam int DISP_DEPTH = 20;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] FIFO_FULL = 4'h8;
    localparam logic [2:0] LAST_ROW = 3'h7;

    // Whole block state, registered as one word
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic sel;
        logic reg_b;
        logic force_b;
        logic blank;
        logic [1:0] in_mode;
        logic [1:0] out_mode;
        logic deep8a;
        logic deep8b;
        logic [4:0] ptr;
        logic ab;
        logic [3:0] acc_out;
        logic [DISP_DEPTH-1:0][3:0] dispa;
        logic [DISP_DEPTH-1:0][3:0] dispb;
        logic [CNT_W-1:0] cnt;
        logic [2:0] row;
        logic half;
        logic [4:0] gas_idx;
        logic [FIFO_DEPTH-1:0][7:0] fifo;
        logic [2:0] wr;
        logic [2:0] rd;
        logic [3:0] count;
        logic over;
        logic [5:0] cand;
        logic cand_v;
        logic [CNT_W-1:0] deb;
        logic [5:0] last;
        logic last_v;
        logic strobe_prev;
        logic [7:0] scan;
        logic [3:0] pa;
        logic [3:0] pb;
        logic irq;
    } kdsc_state_s;

endpackage

// ==== kdsc_top.sv ====
// Keyboard/display scan controller: command decode, display refresh, key scan and buffer
//
// Overview of operation
// - Select accepted only with chip address 01
// - Instructions ignored until first addressed select
// - Mode write loads modes from accumulator nibble
// - Bits 3:2 pick display output mode
// - Bits 1:0 pick keyboard input mode
// - Reset gives scanned keyboard, 16-char gas
// - Gas char: low nibble B, top bits A
// - Gas pointer alternates A0, B0, A1, B1
// - Individual mode: A on port A, B on B
// - Gas: 6-bit char, A2 clock, A3 reset
// - Single walking one across eight scan lines
// - Return lines stored at active row's location
// - Half-scan toggle flips after each pass of the eight scan lines
// - Display refresh in step, 180 Hz full scan
// - Keyboard debounce about 11 ms
// - Eight-key FIFO, sensor memory, two-key rollover
// - Interrupt asserted when character enters buffer
// - Status: character count and over-entry flag
// - Clear resets logic, fills and blanks display
// - Select 0100/0101 targets A/B, odd character
// - Select 0111 targets B, forces B high in individual mode
// - Pointer reset clears pointer, sets depths
// - External reset restores 16-deep registers
// - 8-deep register shows low eight characters
`timescale 1ns/1ps

module kdsc_top #(
    parameter int ROW_CYCLES = kdsc_pkg::ROW_CYC,
    parameter int DEB_CYCLES = kdsc_pkg::DEB_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Scan side
    output logic [7:0] scan_drive_lines,
    output logic half_scan_toggle,
    output logic [3:0] port_a_outputs,
    output logic [3:0] port_b_outputs,
    input wire logic [7:0] return_sense_lines,
    input wire logic shift_key,
    input wire logic control_key,
    // Key interrupt
    output logic key_irq_n
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [4:0] disp_len(input logic [1:0] om);
        case (om)
            kdsc_pkg::OUT_GAS20: disp_len = kdsc_pkg::GAS_LEN20;
            kdsc_pkg::OUT_GAS18: disp_len = kdsc_pkg::GAS_LEN18;
            kdsc_pkg::OUT_GAS16: disp_len = kdsc_pkg::GAS_LEN16;
            default: disp_len = kdsc_pkg::IND_LEN;
        endcase
    endfunction

    function automatic logic [3:0] blank_a(input logic [1:0] om);
        blank_a = (om == kdsc_pkg::OUT_INDIV) ? kdsc_pkg::BLANK_IND : kdsc_pkg::BLANK_GAS_A;
    endfunction

    function automatic logic [3:0] blank_b(input logic [1:0] om);
        blank_b = (om == kdsc_pkg::OUT_INDIV) ? kdsc_pkg::BLANK_IND : kdsc_pkg::BLANK_GAS_B;
    endfunction

    function automatic logic [2:0] low_col(input logic [7:0] v);
        low_col = 3'h0;
        for (int k = 7; k >= 0; k--) begin
            if (v[k]) begin
                low_col = 3'(k);
            end
        end
    endfunction

    kdsc_pkg::kdsc_state_s s_q;
    kdsc_pkg::kdsc_state_s s_d;

    logic tick;
    logic take;
    logic push;
    logic pop;
    logic [7:0] push_data;
    logic [7:0] ret;
    logic [5:0] code6;
    logic [3:0] acc;
    logic [3:0] odd;
    logic [3:0] even;
    logic [7:0] op;
    logic gas;
    logic [3:0] pos;
    logic [3:0] ia;
    logic [3:0] ib;
    logic [4:0] len;
    logic dwrite;
    logic dread;
    logic dinc;
    logic [3:0] dval;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        ret = return_sense_lines;
        code6 = {s_q.row, low_col(ret)};
        acc = avs_writedata[kdsc_pkg::CMD_ACC_LSB +: 4];
        op = avs_writedata[kdsc_pkg::CMD_OP_LSB +: 8];
        odd = avs_writedata[kdsc_pkg::SEL_ODD_LSB +: 4];
        even = avs_writedata[kdsc_pkg::SEL_EVEN_LSB +: 4];
        gas = (s_q.out_mode != kdsc_pkg::OUT_INDIV);
        len = disp_len(s_q.out_mode);
        push = 1'b0;
        pop = 1'b0;
        push_data = 8'h00;
        dwrite = 1'b0;
        dread = 1'b0;
        dinc = 1'b0;
        dval = 4'h0;

        // Row timer: sixteen positions per full scan at the refresh rate
        tick = (s_q.cnt == kdsc_pkg::CNT_W'(ROW_CYCLES - 1));
        s_d.cnt = tick ? '0 : s_q.cnt + 1'b1;
        if (tick) begin
            s_d.row = s_q.row + 1'b1;
            if (s_q.row == kdsc_pkg::LAST_ROW) begin
                s_d.half = ~s_q.half;
            end
            s_d.gas_idx = (s_q.gas_idx + 1'b1 >= len) ? 5'h0 : s_q.gas_idx + 1'b1;
        end

        // Return lines sampled at the end of each row, row still driven
        if (tick && s_q.in_mode == kdsc_pkg::IN_SENSOR) begin
            s_d.fifo[s_q.row] = ret;
        end
        if (s_q.cand_v && s_q.deb != '0) begin
            s_d.deb = s_q.deb - 1'b1;
        end
        if (tick && s_q.in_mode == kdsc_pkg::IN_SCANKB) begin
            // Held key released: it may be entered again later
            if (s_q.last_v && s_q.row == s_q.last[5:3] && !ret[s_q.last[2:0]]) begin
                s_d.last_v = 1'b0;
            end
            if (s_q.cand_v && s_q.row == s_q.cand[5:3]) begin
                if (!ret[s_q.cand[2:0]]) begin
                    s_d.cand_v = 1'b0;
                end else if (s_q.deb == '0) begin
                    push = 1'b1;
                    push_data = {control_key, shift_key, s_q.cand};
                    s_d.cand_v = 1'b0;
                    s_d.last = s_q.cand;
                    s_d.last_v = 1'b1;
                end
            end else if (!s_q.cand_v && ret != 8'h00 && !(s_q.last_v && code6 == s_q.last)) begin
                // A second key is taken while the first is still held
                s_d.cand = code6;
                s_d.cand_v = 1'b1;
                s_d.deb = kdsc_pkg::CNT_W'(DEB_CYCLES);
            end
        end
        // Encoded keyboard: strobe edge enters the byte on the return lines
        s_d.strobe_prev = control_key;
        if (s_q.in_mode == kdsc_pkg::IN_ENC && control_key && !s_q.strobe_prev) begin
            push = 1'b1;
            push_data = ret;
        end

        // Bus: one wait cycle, effect and data on the second cycle
        s_d.ack = (avs_read || avs_write) && !s_q.ack;
        take = (avs_read || avs_write) && s_q.ack;
        if (!s_q.ack) begin
            case (avs_address)
                kdsc_pkg::REG_STAT: begin
                    s_d.rdata = '0;
                    s_d.rdata[kdsc_pkg::ST_CNT_LSB +: 4] = s_q.count;
                    s_d.rdata[kdsc_pkg::ST_OVER] = s_q.over;
                    s_d.rdata[kdsc_pkg::ST_SEL] = s_q.sel;
                    s_d.rdata[kdsc_pkg::ST_REGB] = s_q.reg_b;
                    s_d.rdata[kdsc_pkg::ST_BLANK] = s_q.blank;
                    s_d.rdata[kdsc_pkg::ST_IN_LSB +: 2] = s_q.in_mode;
                    s_d.rdata[kdsc_pkg::ST_OUT_LSB +: 2] = s_q.out_mode;
                    s_d.rdata[kdsc_pkg::ST_PTR_LSB +: 5] = s_q.ptr;
                    s_d.rdata[kdsc_pkg::ST_AB] = s_q.ab;
                    s_d.rdata[kdsc_pkg::ST_ACC_LSB +: 4] = s_q.acc_out;
                end
                kdsc_pkg::REG_KEY: begin
                    if (s_q.in_mode == kdsc_pkg::IN_SENSOR) begin
                        s_d.rdata = {24'h000000, s_q.fifo[s_q.ptr[2:0]]};
                    end else if (s_q.count != 4'h0) begin
                        s_d.rdata = {24'h000000, s_q.fifo[s_q.rd]};
                    end else begin
                        s_d.rdata = '0;
                    end
                end
                default: s_d.rdata = '0;
            endcase
        end
        if (take && avs_read && avs_address == kdsc_pkg::REG_KEY
            && s_q.in_mode != kdsc_pkg::IN_SENSOR && s_q.count != 4'h0) begin
            pop = 1'b1;
        end
        if (take && avs_write && avs_address == kdsc_pkg::REG_SEL
            && even[3:2] == kdsc_pkg::CHIP_ADDR) begin
            s_d.sel = 1'b1;
            s_d.reg_b = even[0];
            s_d.ab = even[0];
            s_d.ptr = {1'b0, odd};
            s_d.force_b = (even == kdsc_pkg::SEL_BHI) && !gas;
        end
        if (take && avs_write && avs_address == kdsc_pkg::REG_CMD && s_q.sel) begin
            case (op)
                kdsc_pkg::OP_MODE: begin
                    s_d.out_mode = acc[3:2];
                    if (acc[1:0] != kdsc_pkg::IN_UNUSED) begin
                        s_d.in_mode = acc[1:0];
                    end
                end
                kdsc_pkg::OP_PRST: begin
                    s_d.ptr = 5'h0;
                    s_d.ab = 1'b0;
                    s_d.deep8b = acc[3];
                    s_d.deep8a = acc[2];
                    for (int i = 0; i < kdsc_pkg::DISP_DEPTH; i++) begin
                        s_d.dispa[i] = blank_a(s_q.out_mode);
                        s_d.dispb[i] = blank_b(s_q.out_mode);
                    end
                end
                kdsc_pkg::OP_CLR: begin
                    for (int i = 0; i < kdsc_pkg::DISP_DEPTH; i++) begin
                        s_d.dispa[i] = blank_a(s_q.out_mode);
                        s_d.dispb[i] = blank_b(s_q.out_mode);
                    end
                    s_d.blank = 1'b1;
                    s_d.wr = 3'h0;
                    s_d.rd = 3'h0;
                    s_d.count = 4'h0;
                    s_d.over = 1'b0;
                    s_d.cand_v = 1'b0;
                    s_d.last_v = 1'b0;
                    s_d.fifo = '0;
                end
                kdsc_pkg::OP_WRM: begin
                    dwrite = 1'b1;
                    dinc = 1'b1;
                end
                kdsc_pkg::OP_WMP: dwrite = 1'b1;
                kdsc_pkg::OP_RDM: begin
                    dread = 1'b1;
                    dinc = 1'b1;
                end
                kdsc_pkg::OP_RD3: dread = 1'b1;
                default: ;
            endcase
        end

        // Display memory access at the pointer; gas uses A/B side flag
        if (gas ? s_q.ab : s_q.reg_b) begin
            dval = s_q.dispb[s_q.ptr];
        end else begin
            dval = s_q.dispa[s_q.ptr];
        end
        if (dread) begin
            s_d.acc_out = dval;
        end
        if (dwrite) begin
            s_d.blank = 1'b0;
            if (gas ? s_q.ab : s_q.reg_b) begin
                s_d.dispb[s_q.ptr] = acc;
            end else begin
                s_d.dispa[s_q.ptr] = acc;
            end
        end
        if (dinc) begin
            if (!gas) begin
                s_d.ptr = {1'b0, s_q.ptr[3:0] + 1'b1};
            end else if (!s_q.ab) begin
                s_d.ab = 1'b1;
            end else begin
                s_d.ab = 1'b0;
                s_d.ptr = (s_q.ptr + 1'b1 >= len) ? 5'h0 : s_q.ptr + 1'b1;
            end
        end

        // Key buffer; a key that lands with a clear is still entered
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
            s_d.count = s_d.count - 1'b1;
        end
        if (push) begin
            if (s_d.count == kdsc_pkg::FIFO_FULL) begin
                s_d.over = 1'b1;
            end else begin
                s_d.fifo[s_d.wr] = push_data;
                s_d.wr = s_d.wr + 1'b1;
                s_d.count = s_d.count + 1'b1;
            end
        end
        // Sensor mode holds the line while any intersection reads one
        s_d.irq = (s_q.in_mode == kdsc_pkg::IN_SENSOR) ? (s_q.fifo != '0)
                                                      : (s_d.count != 4'h0);

        // Output registers follow the scan position
        s_d.scan = 8'h01 << s_d.row;
        pos = {s_d.half, s_d.row};
        ia = s_q.deep8a ? {1'b0, s_d.row} : pos;
        ib = s_q.deep8b ? {1'b0, s_d.row} : pos;
        if (!gas) begin
            s_d.pa = s_q.blank ? kdsc_pkg::BLANK_IND : s_q.dispa[ia];
            s_d.pb = (s_q.blank || s_q.force_b) ? kdsc_pkg::BLANK_IND : s_q.dispb[ib];
        end else begin
            // Clock high in the first half of each character slot
            s_d.pa[3] = (s_d.gas_idx == 5'h0);
            s_d.pa[2] = (s_d.cnt < kdsc_pkg::CNT_W'(ROW_CYCLES / 2));
            s_d.pa[1:0] = s_q.blank ? kdsc_pkg::BLANK_GAS_A[1:0] : s_q.dispa[s_d.gas_idx][1:0];
            s_d.pb = s_q.blank ? kdsc_pkg::BLANK_GAS_B : s_q.dispb[s_d.gas_idx];
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.in_mode <= kdsc_pkg::IN_SCANKB;
            s_q.out_mode <= kdsc_pkg::OUT_GAS16;
            s_q.deep8a <= 1'b0;
            s_q.deep8b <= 1'b0;
            s_q.scan <= 8'h01;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata = s_q.rdata;
    assign scan_drive_lines = s_q.scan;
    assign half_scan_toggle = s_q.half;
    assign port_a_outputs = s_q.pa;
    assign port_b_outputs = s_q.pb;
    assign key_irq_n = ~s_q.irq;

endmodule // kdsc_top

// ==== kdsc_sva.sv ====
// Checker: scan timing, bus handshake and key interrupt at the controller's ports
`timescale 1ns/1ps
module kdsc_sva #(
    parameter int ROW_CYCLES = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // Scan side
    input wire logic [7:0] scan_drive_lines,
    input wire logic half_scan_toggle,
    input wire logic [7:0] return_sense_lines,
    input wire logic key_irq_n
);
    // ****
    // Row tracking
    // ****
    logic [7:0] prev_q;
    logic [31:0] cnt_q;
    logic seen_q;
    wire logic chg = scan_drive_lines != prev_q;
    // The first row after reset may be short, so it is not timed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_q <= 8'h01;
            cnt_q <= 32'h0;
            seen_q <= 1'b0;
        end else begin
            prev_q <= scan_drive_lines;
            cnt_q <= chg ? 32'h1 : cnt_q + 32'h1;
            seen_q <= seen_q | chg;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence req_start;
        (avs_read || avs_write) && !$past(avs_read) && !$past(avs_write);
    endsequence
    sequence row_wrap;
        scan_drive_lines == 8'h01 && $past(scan_drive_lines) == 8'h80;
    endsequence
    a_scan_onehot: assert property ($onehot(scan_drive_lines))
        else $error("scan lines not one-hot");
    a_scan_walk: assert property (chg |-> scan_drive_lines == {prev_q[6:0], prev_q[7]})
        else $error("scan one did not step by one line");
    a_row_period: assert property (chg && seen_q |-> cnt_q == ROW_CYCLES)
        else $error("row period wrong");
    a_toggle_wrap: assert property (row_wrap |-> $changed(half_scan_toggle))
        else $error("half toggle missed scan wrap");
    a_toggle_only: assert property ($changed(half_scan_toggle) |-> row_wrap)
        else $error("half toggle moved mid scan");
    a_wait_first: assert property (req_start |-> avs_waitrequest)
        else $error("no wait in first request cycle");
    a_wait_one: assert property (req_start |=> !avs_waitrequest)
        else $error("answer not after one wait");
    a_irq_cause: assert property ($fell(key_irq_n) |-> $past(return_sense_lines, 1) != 8'h00
        || $past(return_sense_lines, 2) != 8'h00 || $past(return_sense_lines, 3) != 8'h00)
        else $error("interrupt without a key");
endmodule // kdsc_sva

bind kdsc_top kdsc_sva #(.ROW_CYCLES(ROW_CYCLES)) u_sva (.mclk(mclk), .rst(rst),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .scan_drive_lines(scan_drive_lines), .half_scan_toggle(half_scan_toggle),
    .return_sense_lines(return_sense_lines), .key_irq_n(key_irq_n));

// ==== kdsc_matrix.sv ====
// Partner: one switch of the key matrix, seen on the return lines
`timescale 1ns/1ps
module kdsc_matrix (
    // Scan side
    input wire logic [7:0] scan_drive_lines,
    output logic [7:0] return_sense_lines,
    // Key under test
    input wire logic press,
    input wire logic [2:0] row,
    input wire logic [2:0] col
);
    // Return lines are pulled low, so an open switch reads zero, never a held value
    assign return_sense_lines = (press && scan_drive_lines[row]) ? 8'h01 << col : 8'h00;
endmodule // kdsc_matrix

// ==== tb_top.sv ====
// Testbench: selection, modes, display refresh and key buffer of the scan controller
`timescale 1ns/1ps
module tb_top;
    // ****
    // Bench
    // ****
    localparam int ROWC = 8;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] scan_drive_lines;
    logic half_scan_toggle;
    logic [3:0] port_a_outputs;
    logic [3:0] port_b_outputs;
    logic [7:0] return_sense_lines;
    logic shift_key = 1'b0;
    logic key_irq_n;
    logic press = 1'b0, control_key = 1'b0;
    logic [2:0] krow = 3'h0;
    logic [2:0] kcol = 3'h0;
    logic [31:0] lfsr = 32'h023b9361;
    logic [31:0] rd;
    logic [3:0] ea [16];
    logic [3:0] eb [16];
    logic [7:0] keys [9];
    int failures = 0;
    int total_checks = 0;
    always #5 mclk = ~mclk;
    kdsc_top #(.ROW_CYCLES(ROWC), .DEB_CYCLES(20)) dut (.mclk(mclk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .scan_drive_lines(scan_drive_lines),
        .half_scan_toggle(half_scan_toggle), .port_a_outputs(port_a_outputs),
        .port_b_outputs(port_b_outputs), .return_sense_lines(return_sense_lines),
        .shift_key(shift_key), .control_key(control_key), .key_irq_n(key_irq_n));
    kdsc_matrix u_mat (.scan_drive_lines(scan_drive_lines), .return_sense_lines(return_sense_lines),
        .press(press), .row(krow), .col(kcol));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tmo();
        failures++;
        end_sim();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // Request held until the edge after waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(negedge mclk);
        for (n = 0; n < 20 && avs_waitrequest !== 1'b0; n++) @(negedge mclk);
        if (n == 20) tmo();
        @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [3:0] acc);
        bus(1'b1, kdsc_pkg::REG_CMD, {20'h0, acc, op});
    endtask
    task automatic sel(input logic [7:0] b);
        bus(1'b1, kdsc_pkg::REG_SEL, {24'h0, b});
    endtask
    task automatic stat();
        bus(1'b0, kdsc_pkg::REG_STAT, 32'h0);
    endtask
    task automatic blank();
        ea = '{default: 4'hf};
        eb = '{default: 4'hf};
    endtask
    task automatic fill();
        int j;
        for (j = 0; j < 16; j++) begin
            ea[j] = lfsr[3:0];
            eb[j] = lfsr[7:4];
            lfsr = nxt(lfsr);
            sel({4'h4, 4'(j)});
            cmd(kdsc_pkg::OP_WMP, ea[j]);
            sel({4'h5, 4'(j)});
            cmd(kdsc_pkg::OP_WMP, eb[j]);
        end
    endtask
    // Checks ports against the position named by scan line and half toggle
    task automatic obs(input logic d8a, input logic fh);
        int n;
        int r;
        logic [7:0] s;
        repeat (16) begin
            s = scan_drive_lines;
            for (n = 0; n < 40 && scan_drive_lines === s; n++) @(negedge mclk);
            if (n == 40) tmo();
            repeat (3) @(negedge mclk);
            r = $clog2(scan_drive_lines);
            chk(port_a_outputs, ea[{d8a ? 1'b0 : half_scan_toggle, r[2:0]}], "port a");
            chk(port_b_outputs, fh ? 4'hf : eb[{half_scan_toggle, r[2:0]}], "port b");
        end
    endtask
    initial begin
        int i;
        int n;
        logic [3:0] a;
        logic [1:0] im;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk(scan_drive_lines, 8'h01, "scan at reset");
        stat();
        chk(rd[11:5], 7'h68, "modes after reset");
        cmd(kdsc_pkg::OP_MODE, 4'h0);
        for (i = 0; i < 3; i++) begin
            sel({2'(i * 2), 6'h04});
            stat();
            chk(rd[11:5], 7'h68, "unaddressed");
        end
        sel(8'h40);
        stat();
        chk(rd[5], 1'b1, "selected");
        bus(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        $display("test select done");
        im = 2'h1;
        for (i = 0; i < 20; i++) begin
            a = (i < 16) ? 4'(i) : lfsr[3:0];
            lfsr = nxt(lfsr);
            cmd(kdsc_pkg::OP_MODE, a);
            im = (a[1:0] == 2'h3) ? im : a[1:0];
            stat();
            chk(rd[11:8], {a[3:2], im}, "modes");
        end
        $display("test modes done");
        cmd(kdsc_pkg::OP_MODE, 4'h1);
        sel(8'h49);
        stat();
        chk(rd[16:12], 5'h09, "pointer set");
        cmd(kdsc_pkg::OP_PRST, 4'h0);
        stat();
        chk(rd[16:12], 5'h00, "pointer reset");
        fill();
        sel(8'h45);
        cmd(kdsc_pkg::OP_RD3, 4'h0);
        stat();
        chk(rd[23:20], ea[5], "read back a");
        obs(1'b0, 1'b0);
        sel(8'h70);
        obs(1'b0, 1'b1);
        sel(8'h40);
        cmd(kdsc_pkg::OP_PRST, 4'h4);
        blank();
        obs(1'b0, 1'b0);
        fill();
        obs(1'b1, 1'b0);
        cmd(kdsc_pkg::OP_CLR, 4'h0);
        blank();
        obs(1'b0, 1'b0);
        $display("test display done");
        cmd(kdsc_pkg::OP_MODE, 4'hd);
        cmd(kdsc_pkg::OP_PRST, 4'h0);
        cmd(kdsc_pkg::OP_WRM, 4'h3);
        stat();
        chk({rd[17], rd[16:12]}, 6'h20, "gas step one");
        cmd(kdsc_pkg::OP_WRM, 4'h5);
        stat();
        chk({rd[17], rd[16:12]}, 6'h01, "gas step two");
        cmd(kdsc_pkg::OP_CLR, 4'h0);
        repeat (20) @(negedge mclk);
        chk({port_a_outputs[1:0], port_b_outputs}, 6'h20, "gas blank");
        a[0] = port_a_outputs[2];
        for (n = 0; n < 500 && port_a_outputs[2] === a[0]; n++) @(negedge mclk);
        if (n == 500) tmo();
        $display("test gas done");
        for (i = 0; i < 9; i++) begin
            @(posedge mclk);
            keys[i] = {lfsr[4], lfsr[3], 3'(i), (i == 8) ? ~keys[0][2:0] : lfsr[2:0]};
            krow <= keys[i][5:3];
            kcol <= keys[i][2:0];
            shift_key <= lfsr[3];
            control_key <= lfsr[4];
            press <= 1'b1;
            lfsr = nxt(lfsr);
            for (n = 0; n < 60 && rd[4:0] !== (i < 8 ? 5'(i + 1) : 5'h18); n++) stat();
            if (n == 60) tmo();
            @(posedge mclk);
            press <= 1'b0;
            repeat (24 * ROWC) @(posedge mclk);
        end
        chk(key_irq_n, 1'b0, "irq with keys");
        for (i = 0; i < 8; i++) begin
            bus(1'b0, kdsc_pkg::REG_KEY, 32'h0);
            chk(rd[7:0], keys[i], "key order");
        end
        stat();
        chk(rd[4:0], 5'h10, "buffer empty");
        chk(key_irq_n, 1'b1, "irq after drain");
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        stat();
        chk(rd[11:0], 12'hd00, "state after second reset");
        $display("test keys done");
        end_sim();
    end
endmodule // tb_top
